/* File: design/ppc_pkg.sv */
// Constants for the byte-wide passive configuration port.
// Assumes a 40 MHz system clock; all times are turned into cycles here.
package ppc_pkg;

  // System clock rate
  localparam int unsigned SYS_MHZ          = 40;

  // Times in their own units, as printed
  localparam int unsigned REQ_TO_LOW_NS    = 800;
  localparam int unsigned STATUS_MIN_US    = 10;
  localparam int unsigned STATUS_MAX_US    = 500;
  localparam int unsigned INIT_MIN_US      = 55;
  localparam int unsigned INIT_MAX_US      = 150;
  localparam int unsigned POR_DEFAULT_US   = 100;

  // Cycle counts: microsecond times multiply exactly, the nanosecond time rounds down
  localparam int unsigned REQ_TO_LOW_CYC   = (REQ_TO_LOW_NS * SYS_MHZ) / 1000;
  localparam int unsigned STATUS_MIN_CYC   = STATUS_MIN_US * SYS_MHZ;
  localparam int unsigned STATUS_MAX_CYC   = STATUS_MAX_US * SYS_MHZ;
  localparam int unsigned INIT_MIN_CYC     = INIT_MIN_US * SYS_MHZ;
  localparam int unsigned INIT_MAX_CYC     = INIT_MAX_US * SYS_MHZ;
  localparam int unsigned POR_DEFAULT_CYC  = POR_DEFAULT_US * SYS_MHZ;

  // User initialisation clock periods before user mode
  localparam int unsigned USER_INIT_PERIODS = 8532;

  // Falling link clock edges needed to begin initialisation
  localparam logic [1:0]  INIT_FALLS       = 2'h2;

  // Link byte phase: in secure mode one byte every fourth edge
  localparam logic [1:0]  PHASE_LAST       = 2'h3;

  // Widths
  localparam int unsigned CNT_W            = 24;
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned UIO_W            = 7;

  // Sequencer states
  typedef enum logic [2:0] {
    PPC_POR,
    PPC_RESET,
    PPC_LOAD,
    PPC_WAIT_INIT,
    PPC_INIT,
    PPC_USER
  } ppc_state_t;

endpackage

/* File: design/ppc_top.sv */
// Passive parallel configuration port: reset sequencer on the system clock,
// byte capture on the host's configuration clock.
// Assumes external pull-ups on the two open-drain lines and a host that
// drives the configuration clock and data bus.
// How it works
// - Status line pulled low within 800 ns of request falling.
// - Complete line driven low within 800 ns of request falling.
// - Status low pulse lasts between 10 and 500 us.
// - Status released within 500 us of request rising, unless host stretches.
// - Status held low during the power-on-reset delay.
// - Complete held low after power-up and through configuration.
// - User mode: all lines high; request low restarts configuration.
// - Internal oscillator: user mode 55 to 150 us after complete rises.
// - User clock option: user mode after 8532 user clock periods.
// - After configuration data bits 7..1 become user I/O; bit 0 stays dedicated.
// - Plain mode: one byte captured every rising clock edge.
// - Secure mode: one byte every fourth edge, then three processing edges.
`timescale 1ns/10ps
module ppc_top #(
  parameter int unsigned POR_CYC        = ppc_pkg::POR_DEFAULT_CYC,
  parameter int unsigned USER_INIT_PER  = ppc_pkg::USER_INIT_PERIODS
) (
  // System clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       rstn_i,
  // Options
  input  wire logic                       secure_mode_i,
  input  wire logic                       use_user_clock_i,
  input  wire logic [ppc_pkg::UIO_W-1:0]  dual_purpose_i,
  // Host pins
  input  wire logic                       reconfig_request_n_i,
  input  wire logic                       status_error_n_i,
  output logic                            status_error_n_o,
  output logic                            status_error_n_oe_o,
  input  wire logic                       config_complete_i,
  output logic                            config_complete_o,
  output logic                            config_complete_oe_o,
  input  wire logic                       user_init_clock_i,
  // Link clock domain
  input  wire logic                       config_clock_i,
  input  wire logic [ppc_pkg::DATA_W-1:0] config_data_i,
  output logic      [ppc_pkg::DATA_W-1:0] cfg_byte_o,
  output logic                            cfg_byte_valid_o,
  input  wire logic                       image_done_i,
  // Device state
  output logic                            loading_o,
  output logic                            user_mode_o,
  output logic      [ppc_pkg::UIO_W-1:0]  user_io_en_o
);
  import ppc_pkg::*;

  ppc_state_t             state_q, state_d;
  logic [CNT_W-1:0]       cnt_q, cnt_d;
  logic [2:0]             req_s_q;
  logic [1:0]             cc_s_q;
  logic [2:0]             uck_s_q;
  logic [1:0]             done_s_q;
  logic [1:0]             go_s_q;
  logic                   secure_q;
  logic                   user_clk_opt_q;
  logic                   status_oe_q;
  logic                   complete_oe_q;
  logic                   user_mode_q;
  logic [UIO_W-1:0]       uio_en_q;
  logic                   load_en_q;

  // Link domain
  logic [1:0]             phase_q;
  logic                   done_q;
  logic [1:0]             falls_q;
  logic [DATA_W-1:0]      byte_q;
  logic                   valid_q;

  // Decoded pin events
  wire  req_low      = ~req_s_q[1];
  wire  req_fell     = req_s_q[2] & ~req_s_q[1];
  wire  uck_rise     = uck_s_q[1] & ~uck_s_q[2];
  wire  cc_high      = cc_s_q[1];
  wire  image_done   = done_s_q[1];
  wire  init_go      = go_s_q[1];
  wire  cnt_zero     = (cnt_q == '0);
  wire  status_pulse_ok = (cnt_q >= CNT_W'(STATUS_MIN_CYC));
  wire  byte_edge    = ~secure_q | (phase_q == 2'h0);
  // The edge that raises the end flag already carries no byte
  wire  take_byte    = byte_edge & ~done_q & ~image_done_i;
  wire  init_target_hit = user_clk_opt_q ? (cnt_q >= CNT_W'(USER_INIT_PER))
                                         : (cnt_q >= CNT_W'(INIT_MIN_CYC));
  wire  cnt_step     = user_clk_opt_q ? uck_rise : 1'b1;
  wire  drive_status = (state_d == PPC_POR) | (state_d == PPC_RESET);
  wire  drive_done   = (state_d == PPC_POR) | (state_d == PPC_RESET)
                     | (state_d == PPC_LOAD);

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      req_s_q  <= 3'h7;
      cc_s_q   <= 2'h0;
      uck_s_q  <= 3'h0;
      done_s_q <= 2'h0;
      go_s_q   <= 2'h0;
    end else begin
      req_s_q  <= {req_s_q[1:0], reconfig_request_n_i};
      cc_s_q   <= {cc_s_q[0], config_complete_i};
      uck_s_q  <= {uck_s_q[1:0], user_init_clock_i};
      done_s_q <= {done_s_q[0], done_q};
      go_s_q   <= {go_s_q[0], (falls_q == INIT_FALLS)};
    end
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      PPC_POR: begin
        if (cnt_zero) begin
          state_d = PPC_RESET;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      PPC_RESET: begin
        if (!status_pulse_ok) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
        if (!req_low && status_pulse_ok) begin
          state_d = PPC_LOAD;
          cnt_d   = '0;
        end
      end
      PPC_LOAD: begin
        // Complete is still pulled low here, so only the image end is awaited
        if (image_done) begin
          state_d = PPC_WAIT_INIT;
        end
      end
      PPC_WAIT_INIT: begin
        cnt_d = '0;
        if (init_go && cc_high) begin
          state_d = PPC_INIT;
        end
      end
      PPC_INIT: begin
        if (init_target_hit) begin
          state_d = PPC_USER;
        end else if (cnt_step) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      PPC_USER: begin
        cnt_d = '0;
      end
      default: begin
        state_d = PPC_RESET;
        cnt_d   = '0;
      end
    endcase
    if (state_q != PPC_POR && req_fell) begin
      state_d = PPC_RESET;
      cnt_d   = '0;
    end else if (state_q != PPC_POR && state_q != PPC_RESET && req_low) begin
      state_d = PPC_RESET;
      cnt_d   = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_q <= PPC_POR;
      cnt_q   <= CNT_W'(POR_CYC);
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Registered pin drives and options
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      status_oe_q    <= 1'b1;
      complete_oe_q  <= 1'b1;
      user_mode_q    <= 1'b0;
      uio_en_q       <= '0;
      load_en_q      <= 1'b0;
      secure_q       <= 1'b0;
      user_clk_opt_q <= 1'b0;
    end else begin
      status_oe_q   <= drive_status;
      complete_oe_q <= drive_done;
      user_mode_q   <= (state_d == PPC_USER);
      uio_en_q      <= (state_d == PPC_USER) ? dual_purpose_i : '0;
      load_en_q     <= (state_d == PPC_LOAD) | (state_d == PPC_WAIT_INIT);
      if (state_q == PPC_RESET) begin
        secure_q       <= secure_mode_i;
        user_clk_opt_q <= use_user_clock_i;
      end
    end
  end

  // Byte capture on the link clock; cleared while not loading
  always_ff @(posedge config_clock_i or negedge load_en_q) begin
    if (!load_en_q) begin
      phase_q <= 2'h0;
      byte_q  <= '0;
      valid_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      phase_q <= (phase_q == PHASE_LAST) ? 2'h0 : phase_q + 2'h1;
      valid_q <= take_byte;
      if (take_byte) begin
        byte_q <= config_data_i;
      end
      if (image_done_i) begin
        done_q <= 1'b1;
      end
    end
  end

  // Falling edges after the image is complete start initialisation
  always_ff @(negedge config_clock_i or negedge load_en_q) begin
    if (!load_en_q) begin
      falls_q <= 2'h0;
    end else if (done_q && falls_q != INIT_FALLS) begin
      falls_q <= falls_q + 2'h1;
    end
  end

  // Outputs
  assign status_error_n_o     = 1'b0;
  assign status_error_n_oe_o  = status_oe_q;
  assign config_complete_o    = 1'b0;
  assign config_complete_oe_o = complete_oe_q;
  assign cfg_byte_o           = byte_q;
  assign cfg_byte_valid_o     = valid_q;
  assign loading_o            = load_en_q;
  assign user_mode_o          = user_mode_q;
  assign user_io_en_o         = uio_en_q;

endmodule

/* File: bench/ppc_chk.sv */
// Checker for the passive configuration port, bound to its top module.
// Assumes a 40 MHz system clock and pull-ups on both open-drain lines.
`timescale 1ns/10ps
module ppc_chk #(
  parameter int unsigned POR_CYC = 8
) (
  input wire logic clk_sys_i, rstn_i, secure_mode_i, use_user_clock_i, image_done_i,
  input wire logic reconfig_request_n_i, config_complete_i, config_clock_i, loading_o,
  input wire logic status_error_n_oe_o, config_complete_oe_o, cfg_byte_valid_o, user_mode_o,
  input wire logic [ppc_pkg::DATA_W-1:0] config_data_i, cfg_byte_o
);
  import ppc_pkg::*;
  int unsigned since_q, low_q, rel_q, cd_q;
  always_ff @(posedge clk_sys_i) begin
    since_q <= !rstn_i ? 0 : (since_q < POR_CYC ? since_q + 1 : since_q);
    low_q   <= status_error_n_oe_o ? low_q + 1 : 0;
    rel_q   <= (reconfig_request_n_i && status_error_n_oe_o) ? rel_q + 1 : 0;
    cd_q    <= (config_complete_i && !user_mode_o) ? cd_q + 1 : 0;
  end
  a_req_status_low: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(reconfig_request_n_i) && (loading_o || user_mode_o)
    |-> ##[0:32] status_error_n_oe_o) else $error("status not pulled low in time");
  a_req_done_low: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(reconfig_request_n_i) && (loading_o || user_mode_o)
    |-> ##[0:32] config_complete_oe_o) else $error("complete not pulled low in time");
  a_status_min: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(status_error_n_oe_o) |-> low_q >= STATUS_MIN_CYC)
    else $error("status low pulse too short");
  a_status_release: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rel_q <= STATUS_MAX_CYC) else $error("status held low too long after request high");
  a_por_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    since_q < POR_CYC |-> status_error_n_oe_o) else $error("status released during power-on delay");
  a_done_low_reset: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    status_error_n_oe_o |-> config_complete_oe_o)
    else $error("complete released while in reset phase");
  a_user_lines: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    user_mode_o |-> !status_error_n_oe_o && !config_complete_oe_o)
    else $error("line pulled low in user mode");
  a_init_time: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(user_mode_o) && !use_user_clock_i
    |-> cd_q >= INIT_MIN_CYC && cd_q <= INIT_MAX_CYC) else $error("user mode entry time off");
  a_byte_plain: assert property (@(posedge config_clock_i) disable iff (!rstn_i || !loading_o)
    $past(loading_o) && !secure_mode_i && !image_done_i
    |=> cfg_byte_valid_o && cfg_byte_o == $past(config_data_i)) else $error("byte not captured");
  a_byte_secure: assert property (@(posedge config_clock_i) disable iff (!rstn_i || !loading_o)
    cfg_byte_valid_o && secure_mode_i |=> !cfg_byte_valid_o [*3]) else $error("secure byte rate");
  c_user: cover property (@(posedge clk_sys_i) disable iff (!rstn_i) $rose(user_mode_o));
  c_restart: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $fell(reconfig_request_n_i) && user_mode_o);
  c_secure: cover property (@(posedge config_clock_i) disable iff (!rstn_i)
    cfg_byte_valid_o && secure_mode_i);
endmodule

/* File: bench/ppc_host.sv */
// Host model: drives request, configuration clock, data bus and done flag.
// Assumes pulled-up status and complete lines; the clock stands low between frames.
`timescale 1ns/10ps
module ppc_host (
  output logic       req_n_o = 1'b1,
  output logic       config_clock_o = 1'b0,
  output logic [7:0] data_o = 8'h00,
  output logic       done_o = 1'b0,
  input  wire logic  status_n_i,
  input  wire logic  complete_i,
  input  wire logic  secure_i
);
  task automatic restart();
    req_n_o = 1'b0;
    #2000;
    req_n_o = 1'b1;
  endtask
  task automatic edge_once();
    #6 config_clock_o = 1'b1;
    #6 config_clock_o = 1'b0;
  endtask
  task automatic load(input int n);
    done_o = 1'b0;
    wait (status_n_i === 1'b1);
    #500000;
    for (int i = 0; i < n; i++) begin
      if (status_n_i !== 1'b1) return;
      data_o = 8'h30 + i[7:0];
      repeat (secure_i ? 4 : 1) edge_once();
      data_o = ~data_o;
    end
    done_o = 1'b1;
    repeat (3) edge_once();
    wait (complete_i === 1'b1);
    repeat (2) edge_once();
  endtask
endmodule

/* File: bench/passive_parallel_config_port_tb.sv */
// Testbench for the passive configuration port with a host model.
// Assumes shortened power-on and user-clock counts set at the instance.
`timescale 1ns/10ps
module passive_parallel_config_port_tb;
  import ppc_pkg::*;
  logic clk_sys_i = 0, rstn_i = 0, secure = 0, use_uclk = 0, uclk = 0, uclk_en = 0;
  logic [UIO_W-1:0] dual = 7'h55, uio;
  logic req_n, config_clock, done, st_oe, st_o, cd_oe, cd_o, valid, loading, user;
  logic [7:0] data, byte_q;
  wire st_line = st_oe ? st_o : 1'b1;
  wire cd_line = cd_oe ? cd_o : 1'b1;
  int error_cnt = 0, checks_done = 0, n_got = 0, cyc = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  always #100 if (uclk_en) uclk = ~uclk;
  ppc_top #(.POR_CYC(8), .USER_INIT_PER(16)) u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .secure_mode_i(secure), .use_user_clock_i(use_uclk), .dual_purpose_i(dual),
    .reconfig_request_n_i(req_n), .status_error_n_i(st_line), .status_error_n_o(st_o),
    .status_error_n_oe_o(st_oe), .config_complete_i(cd_line), .config_complete_o(cd_o),
    .config_complete_oe_o(cd_oe), .user_init_clock_i(uclk), .config_clock_i(config_clock),
    .config_data_i(data), .cfg_byte_o(byte_q), .cfg_byte_valid_o(valid),
    .image_done_i(done), .loading_o(loading), .user_mode_o(user), .user_io_en_o(uio));
  ppc_host u_host (.req_n_o(req_n), .config_clock_o(config_clock), .data_o(data), .done_o(done),
    .status_n_i(st_line), .complete_i(cd_line), .secure_i(secure));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("wrong value %s exp %0d..%0d got %0d", what, lo, hi, got);
    end
  endtask
  always @(negedge config_clock) if (valid === 1'b1) begin
    chk("byte", 32'h30 + n_got, 32'(byte_q));
    n_got++;
  end
  always @(posedge clk_sys_i) cyc <= (cd_line === 1'b1 && !(use_uclk && !uclk_en)) ? cyc + 1 : 0;
  task automatic wait_user(input int lo, input int hi);
    int n = 0;
    while (user !== 1'b1 && n < 20000) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk_rng("user mode entry", lo, hi, cyc);
  endtask
  task automatic t_power_up();
    chk("status oe", 32'h1, 32'(st_oe));
    chk("complete oe", 32'h1, 32'(cd_oe));
    u_host.load(6);
    chk("byte count", 32'h6, 32'(n_got));
    wait_user(2200, 6000);
    @(negedge clk_sys_i);
    chk("lines", 32'h7, 32'({req_n, st_line, cd_line}));
    chk("user io", 32'(dual), 32'(uio));
    $display("test power_up done");
  endtask
  task automatic t_secure_uclk();
    int t = 0;
    @(negedge clk_sys_i);
    secure = 1;
    use_uclk = 1;
    n_got = 0;
    fork u_host.restart(); join_none
    while (st_oe !== 1'b1 && t < 100) begin
      @(negedge clk_sys_i);
      t++;
    end
    chk_rng("status fall", 0, 32, t);
    chk("complete oe", 32'h1, 32'(cd_oe));
    t = 0;
    while (st_oe === 1'b1 && t < 30000) begin
      @(negedge clk_sys_i);
      t++;
    end
    chk_rng("status low", 400, 20000, t);
    u_host.load(4);
    chk("byte count", 32'h4, 32'(n_got));
    @(negedge clk_sys_i);
    uclk_en = 1;
    wait_user(120, 150);
    $display("test secure_uclk done");
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1;
    t_power_up();
    t_secure_uclk();
    stop_test();
  end
  initial begin
    #1500000;
    error_cnt++;
    stop_test();
  end
endmodule
bind ppc_top ppc_chk #(.POR_CYC(POR_CYC)) u_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .secure_mode_i(secure_mode_i), .use_user_clock_i(use_user_clock_i),
  .image_done_i(image_done_i), .reconfig_request_n_i(reconfig_request_n_i),
  .config_complete_i(config_complete_i), .config_clock_i(config_clock_i),
  .loading_o(loading_o), .status_error_n_oe_o(status_error_n_oe_o),
  .config_complete_oe_o(config_complete_oe_o), .cfg_byte_valid_o(cfg_byte_valid_o),
  .user_mode_o(user_mode_o), .config_data_i(config_data_i), .cfg_byte_o(cfg_byte_o));
